/* File: logic/fsp_pkg.sv */
package fsp_pkg;
    localparam int CLK_MHZ = 100;
    localparam int T_WP_NS = 70;
    localparam int T_ACC_NS = 120;
    localparam int T_UNLOCK_NS = 2000;
    localparam int T_RST_NS = 500;
    localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
    // Two extra cycles cover the data synchroniser
    localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000 + 2;
    localparam int UNLOCK_CYC = (T_UNLOCK_NS * CLK_MHZ + 999) / 1000;
    localparam int RST_CYC = (T_RST_NS * CLK_MHZ + 999) / 1000;

    localparam int ADDR_W = 26;
    localparam int DATA_W = 16;
    localparam int CNT_W = 16;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_WDATA = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_RDATA = 8'h10;
    localparam logic [7:0] OFS_PWD_LO = 8'h14;
    localparam logic [7:0] OFS_PWD_HI = 8'h18;

    localparam int CTRL_GO = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_NV_OP = 4;
    localparam int CTRL_LOCK_CMD = 5;
    localparam int CTRL_ERASE = 6;

    localparam int ST_BUSY = 0;
    localparam int ST_PASS = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_LOCK_OWED = 3;
    localparam int ST_REFUSED = 4;

    localparam int TOGGLE_BIT = 6;
    localparam logic [7:0] POLL_PROG_OK = 8'h00;
    localparam logic [7:0] POLL_ERASE_OK = 8'h01;

    typedef enum logic [2:0] {
        FSP_OP_WRITE = 3'b000,
        FSP_OP_READ = 3'b001,
        FSP_OP_POLL = 3'b010,
        FSP_OP_UNLOCK = 3'b011,
        FSP_OP_HWRST = 3'b100
    } fsp_op_t;
endpackage : fsp_pkg

/* File: logic/fsp_cyc_if.sv */
`timescale 1ns/10ps
interface fsp_cyc_if;
    logic req;
    logic we;
    logic [fsp_pkg::ADDR_W-1:0] addr;
    logic [fsp_pkg::DATA_W-1:0] wdata;
    logic done;
    logic [fsp_pkg::DATA_W-1:0] rdata;
    modport master (output req, output we, output addr, output wdata, input done, input rdata);
    modport engine (input req, input we, input addr, input wdata, output done, output rdata);
endinterface : fsp_cyc_if

/* File: logic/fsp_cycle.sv */
`timescale 1ns/10ps
module fsp_cycle (
    input wire logic clk_sys,
    input wire logic rst_sync_b,
    fsp_cyc_if.engine cyc,
    output logic [fsp_pkg::ADDR_W-1:0] flash_addr,
    input wire logic [fsp_pkg::DATA_W-1:0] flash_dq_i,
    output logic [fsp_pkg::DATA_W-1:0] flash_dq_o,
    output logic flash_dq_oe,
    output logic flash_ce_b,
    output logic flash_oe_b,
    output logic flash_we_b
);
    typedef enum logic [1:0] {
        FSP_C_IDLE = 2'b00,
        FSP_C_ACT = 2'b01,
        FSP_C_HOLD = 2'b10
    } fsp_cstate_t;

    typedef struct packed {
        fsp_cstate_t state;
        logic we;
        logic [7:0] cnt;
        logic [fsp_pkg::ADDR_W-1:0] addr;
        logic [fsp_pkg::DATA_W-1:0] wdata;
        logic [fsp_pkg::DATA_W-1:0] sync1;
        logic [fsp_pkg::DATA_W-1:0] sync2;
        logic [fsp_pkg::DATA_W-1:0] rdata;
    } fsp_cyc_st_t;

    fsp_cyc_st_t st_reg;
    fsp_cyc_st_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.sync1 = flash_dq_i;
        st_next.sync2 = st_reg.sync1;
        unique case (st_reg.state)
            FSP_C_IDLE: begin
                if (cyc.req) begin
                    st_next.state = FSP_C_ACT;
                    st_next.we = cyc.we;
                    st_next.addr = cyc.addr;
                    st_next.wdata = cyc.wdata;
                    st_next.cnt = cyc.we ? 8'(fsp_pkg::WP_CYC) : 8'(fsp_pkg::ACC_CYC);
                end
            end
            FSP_C_ACT: begin
                if (st_reg.cnt > 8'h01) begin
                    st_next.cnt = st_reg.cnt - 8'h01;
                end else begin
                    st_next.state = FSP_C_HOLD;
                    if (!st_reg.we) begin
                        st_next.rdata = st_reg.sync2;
                    end
                end
            end
            FSP_C_HOLD: begin
                st_next.state = FSP_C_IDLE;
            end
            default: st_next.state = FSP_C_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Address and data stay put through the hold cycle so the rising strobe sees them
    assign cyc.done = (st_reg.state == FSP_C_HOLD);
    assign cyc.rdata = st_reg.rdata;
    assign flash_addr = st_reg.addr;
    assign flash_dq_o = st_reg.wdata;
    assign flash_dq_oe = st_reg.we && (st_reg.state != FSP_C_IDLE);
    assign flash_ce_b = (st_reg.state == FSP_C_IDLE);
    assign flash_we_b = !(st_reg.we && st_reg.state == FSP_C_ACT);
    assign flash_oe_b = !(!st_reg.we && st_reg.state == FSP_C_ACT);
endmodule : fsp_cycle

/* File: logic/fsp_host.sv */
`timescale 1ns/10ps
module fsp_host (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [fsp_pkg::ADDR_W-1:0] flash_addr,
    input wire logic [fsp_pkg::DATA_W-1:0] flash_dq_i,
    output logic [fsp_pkg::DATA_W-1:0] flash_dq_o,
    output logic flash_dq_oe,
    output logic flash_ce_b,
    output logic flash_oe_b,
    output logic flash_we_b,
    output logic flash_reset_b
);
    typedef enum logic [2:0] {
        FSP_IDLE = 3'b000,
        FSP_SPACE = 3'b001,
        FSP_ISSUE = 3'b010,
        FSP_SETTLE = 3'b011,
        FSP_RSTP = 3'b100
    } fsp_state_t;

    typedef struct packed {
        fsp_state_t state;
        fsp_pkg::fsp_op_t op;
        logic nv_op;
        logic lock_cmd;
        logic erase;
        logic req;
        logic [1:0] word_idx;
        logic first;
        logic prev6;
        logic pass;
        logic fail;
        logic lock_owed;
        logic refused;
        logic rst_pin;
        logic [fsp_pkg::CNT_W-1:0] cnt;
        logic [fsp_pkg::CNT_W-1:0] since_unlock;
        logic [fsp_pkg::ADDR_W-1:0] addr;
        logic [fsp_pkg::DATA_W-1:0] wdata;
        logic [fsp_pkg::DATA_W-1:0] rdata;
        logic [63:0] pwd;
        logic [31:0] prdata;
    } fsp_st_t;

    fsp_st_t st_reg;
    fsp_st_t st_next;
    logic rst_s1;
    logic rst_sync_b;
    fsp_cyc_if cyc ();

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1 <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_sync_b <= rst_s1;
        end
    end

    fsp_cycle u_cycle (
        .clk_sys(clk_sys),
        .rst_sync_b(rst_sync_b),
        .cyc(cyc),
        .flash_addr(flash_addr),
        .flash_dq_i(flash_dq_i),
        .flash_dq_o(flash_dq_o),
        .flash_dq_oe(flash_dq_oe),
        .flash_ce_b(flash_ce_b),
        .flash_oe_b(flash_oe_b),
        .flash_we_b(flash_we_b)
    );

    ////////////////////////////////////////////////////////////////////////////////
    logic setup;
    logic wr_go;
    logic mapped;
    logic [7:0] low_byte;
    logic [7:0] poll_ok;

    assign setup = psel && !penable;
    assign wr_go = pready && pwrite && paddr == fsp_pkg::OFS_CTRL && pwdata[fsp_pkg::CTRL_GO];
    assign mapped = paddr inside {fsp_pkg::OFS_CTRL, fsp_pkg::OFS_ADDR, fsp_pkg::OFS_WDATA,
        fsp_pkg::OFS_STATUS, fsp_pkg::OFS_RDATA, fsp_pkg::OFS_PWD_LO, fsp_pkg::OFS_PWD_HI};
    assign low_byte = cyc.rdata[7:0];
    assign poll_ok = st_reg.erase ? fsp_pkg::POLL_ERASE_OK : fsp_pkg::POLL_PROG_OK;

    always_comb begin
        st_next = st_reg;
        if (st_reg.since_unlock != '1) begin
            st_next.since_unlock = st_reg.since_unlock + 1'b1;
        end
        // Writes land at the access edge; reads are captured in setup so prdata is a flop
        if (pready && pwrite) begin
            unique case (paddr)
                fsp_pkg::OFS_ADDR: st_next.addr = pwdata[fsp_pkg::ADDR_W-1:0];
                fsp_pkg::OFS_WDATA: st_next.wdata = pwdata[fsp_pkg::DATA_W-1:0];
                fsp_pkg::OFS_PWD_LO: st_next.pwd[31:0] = pwdata;
                fsp_pkg::OFS_PWD_HI: st_next.pwd[63:32] = pwdata;
                fsp_pkg::OFS_STATUS: begin
                    if (pwdata[fsp_pkg::ST_PASS]) st_next.pass = 1'b0;
                    if (pwdata[fsp_pkg::ST_FAIL]) st_next.fail = 1'b0;
                    if (pwdata[fsp_pkg::ST_REFUSED]) st_next.refused = 1'b0;
                end
                default: ;
            endcase
        end
        if (setup && !pwrite) begin
            unique case (paddr)
                fsp_pkg::OFS_CTRL: st_next.prdata = {25'h0, st_reg.erase, st_reg.lock_cmd,
                    st_reg.nv_op, st_reg.op, 1'b0};
                fsp_pkg::OFS_ADDR: st_next.prdata = 32'(st_reg.addr);
                fsp_pkg::OFS_WDATA: st_next.prdata = 32'(st_reg.wdata);
                fsp_pkg::OFS_STATUS: st_next.prdata = {27'h0, st_reg.refused, st_reg.lock_owed,
                    st_reg.fail, st_reg.pass, st_reg.state != FSP_IDLE};
                fsp_pkg::OFS_RDATA: st_next.prdata = 32'(st_reg.rdata);
                fsp_pkg::OFS_PWD_LO: st_next.prdata = st_reg.pwd[31:0];
                fsp_pkg::OFS_PWD_HI: st_next.prdata = st_reg.pwd[63:32];
                default: st_next.prdata = 32'h0000_0000;
            endcase
        end

        ////////////////////////////////////////////////////////////////////////////
        unique case (st_reg.state)
            FSP_IDLE: begin
                if (wr_go) begin
                    st_next.op = fsp_pkg::fsp_op_t'(pwdata[fsp_pkg::CTRL_OP_LSB +: 3]);
                    st_next.nv_op = pwdata[fsp_pkg::CTRL_NV_OP];
                    st_next.lock_cmd = pwdata[fsp_pkg::CTRL_LOCK_CMD];
                    st_next.erase = pwdata[fsp_pkg::CTRL_ERASE];
                    st_next.word_idx = 2'b00;
                    st_next.first = 1'b1;
                    unique case (pwdata[fsp_pkg::CTRL_OP_LSB +: 3])
                        fsp_pkg::FSP_OP_UNLOCK: st_next.state = FSP_SPACE;
                        fsp_pkg::FSP_OP_HWRST: begin
                            st_next.state = FSP_RSTP;
                            st_next.rst_pin = 1'b1;
                            st_next.cnt = fsp_pkg::CNT_W'(fsp_pkg::RST_CYC);
                        end
                        default: begin
                            st_next.state = FSP_ISSUE;
                            st_next.req = 1'b1;
                        end
                    endcase
                end
            end
            FSP_SPACE: begin
                // Unlock attempts slower than one per interval defeat password guessing
                if (st_reg.since_unlock >= fsp_pkg::CNT_W'(fsp_pkg::UNLOCK_CYC)) begin
                    st_next.state = FSP_ISSUE;
                    st_next.req = 1'b1;
                end
            end
            FSP_ISSUE: begin
                if (cyc.done) begin
                    st_next.req = 1'b0;
                    st_next.rdata = cyc.rdata;
                    st_next.state = FSP_IDLE;
                    unique case (st_reg.op)
                        fsp_pkg::FSP_OP_WRITE: begin
                            if (st_reg.lock_cmd) st_next.lock_owed = 1'b0;
                        end
                        fsp_pkg::FSP_OP_POLL: begin
                            st_next.first = 1'b0;
                            st_next.prev6 = cyc.rdata[fsp_pkg::TOGGLE_BIT];
                            if (st_reg.first || st_reg.prev6 != cyc.rdata[fsp_pkg::TOGGLE_BIT]) begin
                                st_next.state = FSP_ISSUE;
                                st_next.req = 1'b1;
                            end else if (low_byte == poll_ok) begin
                                st_next.pass = 1'b1;
                                if (st_reg.nv_op) st_next.lock_owed = 1'b1;
                            end else begin
                                st_next.fail = 1'b1;
                            end
                        end
                        fsp_pkg::FSP_OP_UNLOCK: begin
                            st_next.word_idx = st_reg.word_idx + 2'b01;
                            if (st_reg.word_idx == 2'b11) begin
                                st_next.state = FSP_SETTLE;
                                st_next.since_unlock = '0;
                            end else begin
                                st_next.state = FSP_ISSUE;
                                st_next.req = 1'b1;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            FSP_SETTLE: begin
                if (st_reg.since_unlock >= fsp_pkg::CNT_W'(fsp_pkg::UNLOCK_CYC)) begin
                    st_next.state = FSP_IDLE;
                    st_next.pass = 1'b1;
                end
            end
            FSP_RSTP: begin
                if (st_reg.cnt > fsp_pkg::CNT_W'(1)) begin
                    st_next.cnt = st_reg.cnt - 1'b1;
                end else begin
                    st_next.rst_pin = 1'b0;
                    st_next.state = FSP_IDLE;
                end
            end
            default: st_next.state = FSP_IDLE;
        endcase
        // Set wins: a refusal in the same cycle as its clear is kept
        if (wr_go && st_reg.state != FSP_IDLE) begin
            st_next.refused = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st_reg <= '0;
            st_reg.since_unlock <= '1;
            st_reg.pwd <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic [fsp_pkg::DATA_W-1:0] cyc_wdata;

    always_comb begin
        unique case (st_reg.word_idx)
            2'b00: cyc_wdata = st_reg.pwd[15:0];
            2'b01: cyc_wdata = st_reg.pwd[31:16];
            2'b10: cyc_wdata = st_reg.pwd[47:32];
            2'b11: cyc_wdata = st_reg.pwd[63:48];
        endcase
    end

    assign cyc.req = st_reg.req;
    assign cyc.we = st_reg.op == fsp_pkg::FSP_OP_WRITE || st_reg.op == fsp_pkg::FSP_OP_UNLOCK;
    assign cyc.addr = st_reg.addr;
    assign cyc.wdata = st_reg.op == fsp_pkg::FSP_OP_UNLOCK ? cyc_wdata : st_reg.wdata;
    assign prdata = st_reg.prdata;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;
    assign flash_reset_b = !st_reg.rst_pin;
endmodule : fsp_host

/* File: test/fsp_host_sva.sv */
`timescale 1ns/10ps
module fsp_host_chk (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [fsp_pkg::ADDR_W-1:0] flash_addr,
    input wire logic flash_dq_oe,
    input wire logic flash_ce_b,
    input wire logic flash_oe_b,
    input wire logic flash_we_b,
    input wire logic flash_reset_b
);
    logic [7:0] rst_cnt;

    // Too long for a repetition, so the reset pulse is measured here
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_cnt <= 8'h00;
        end else begin
            rst_cnt <= flash_reset_b ? 8'h00 : rst_cnt + 8'h01;
        end
    end

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////////////
    AST_PREADY: assert property (pready == (psel && penable))
        else $error("pready differs from psel and penable");
    AST_SLVERR: assert property (psel && penable && paddr[1:0] == 2'b00
        |-> pslverr == (paddr > 8'h18)) else $error("pslverr wrong for offset");
    AST_WE_LEN: assert property ($fell(flash_we_b) |-> !flash_we_b [*7] ##1 flash_we_b)
        else $error("write strobe not seven cycles");
    AST_WE_HOLD: assert property ($rose(flash_we_b) |-> !flash_ce_b && flash_dq_oe
        ##1 flash_ce_b && !flash_dq_oe) else $error("write hold cycle wrong");
    AST_RD_LEN: assert property ($fell(flash_oe_b)
        |-> !flash_oe_b [*7] ##1 !flash_oe_b [*7] ##1 flash_oe_b)
        else $error("read strobe not fourteen cycles");
    AST_NO_FIGHT: assert property (!flash_oe_b |-> !flash_ce_b && !flash_dq_oe && flash_we_b)
        else $error("data bus contention");
    AST_CE_GAP: assert property ($rose(flash_ce_b) |-> $past(flash_we_b) && $past(flash_oe_b))
        else $error("chip select rose without a hold cycle");
    AST_ADDR_HOLD: assert property (!flash_ce_b && !$past(flash_ce_b) |-> $stable(flash_addr))
        else $error("address moved inside a cycle");
    AST_RST_LEN: assert property ($rose(flash_reset_b) |-> rst_cnt == 8'h32)
        else $error("flash reset pulse length wrong");
    AST_RST_QUIET: assert property (!flash_reset_b |-> flash_ce_b)
        else $error("flash selected during reset pulse");
endmodule : fsp_host_chk

bind fsp_host fsp_host_chk fsp_host_chk_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr), .flash_dq_oe(flash_dq_oe),
    .flash_ce_b(flash_ce_b), .flash_oe_b(flash_oe_b), .flash_we_b(flash_we_b),
    .flash_reset_b(flash_reset_b)
);

/* File: test/fsp_flash_model.sv */
`timescale 1ns/10ps
module fsp_flash_model #(
    // Command codes are arbitrary, offsets 1 to 10 from this base
    parameter logic [15:0] CMD_BASE = 16'h00c0,
    // Serial number contents are arbitrary
    parameter logic [15:0] SN_BASE = 16'h5a00,
    parameter bit SEC_LOCKED = 1'b1
) (
    input wire logic [fsp_pkg::ADDR_W-1:0] addr,
    input wire logic [fsp_pkg::DATA_W-1:0] dq_o,
    input wire logic dq_oe,
    input wire logic ce_b,
    input wire logic oe_b,
    input wire logic we_b,
    input wire logic reset_b,
    input wire logic [3:0] busy_len,
    output logic [fsp_pkg::DATA_W-1:0] dq_i
);
    logic lock = 1'b1;
    logic pwd_mode = 1'b0;
    logic pprog = 1'b0;
    logic tog = 1'b0;
    logic in_op = 1'b0;
    logic [2:0] ucnt = 3'h0;
    logic [3:0] left = 4'h0;
    logic [15:0] nv = 16'hffff;
    logic [15:0] dyn = 16'hffff;
    logic [15:0] tmp = 16'hffff;
    logic [15:0] res, k;
    logic [15:0] out = 16'h0000;
    logic [63:0] pwd = 64'hffff_ffff_ffff_ffff;
    logic [63:0] sh;
    logic in_sec = 1'b0;
    logic [15:0] sec [0:127];

    initial begin
        for (int i = 0; i < 128; i++) sec[i] = (i < 8) ? SN_BASE + 16'(i) : 16'hffff;
    end

    // A released bus shows the inverse of the last word, never a stale copy
    assign dq_i = (!ce_b && !oe_b) ? out : (dq_oe ? dq_o : ~out);

    always @(negedge oe_b) begin
        if (left != 4'h0) begin
            tog = ~tog;
            left = left - 4'h1;
            out = {9'h000, tog, 6'h00};
        end else if (in_op) begin
            out = res;
        end else if (in_sec) begin
            out = sec[addr[6:0]];
        end else begin
            // Status mode stands in for the array whenever left is zero and in_op and in_sec are clear
            out = {10'h000, SEC_LOCKED, lock, tmp[addr[3:0]], nv[addr[3:0]], dyn[addr[3:0]],
                !dyn[addr[3:0]] || (!nv[addr[3:0]] && tmp[addr[3:0]])};
        end
    end

    always @(posedge we_b) begin
        if (!ce_b) begin
            k = dq_o - CMD_BASE;
            in_op = 1'b0;
            if (ucnt != 3'h0) begin
                sh = {dq_o, sh[63:16]};
                ucnt = ucnt - 3'h1;
                if (ucnt == 3'h0 && pprog && !pwd_mode) pwd = pwd & sh;
                if (ucnt == 3'h0 && !pprog && pwd_mode && sh == pwd) lock = 1'b1;
            end else if (in_sec) begin
                // Inside the region protect-bit commands are not decoded; they program the word unless SEC_LOCKED
                if (k == 16'h000a) in_sec = 1'b0;
                else if (!SEC_LOCKED) sec[addr[6:0]] = sec[addr[6:0]] & dq_o;
            end else begin
                case (k)
                    16'h0001, 16'h0002: begin
                        in_op = 1'b1;
                        left = busy_len;
                        res = lock ? k - 16'h0001 : 16'h0020;
                        if (lock && k == 16'h0001) nv[addr[3:0]] = 1'b0;
                        if (lock && k == 16'h0002) nv = 16'hffff;
                    end
                    16'h0003: lock = 1'b0;
                    // Address bits 2 and 1 name the mode bits; both at once abort
                    16'h0004: if (addr[2:1] == 2'b10) pwd_mode = 1'b1;
                    16'h0009: in_sec = 1'b1;
                    16'h0005, 16'h0008: begin
                        ucnt = 3'h4;
                        pprog = k[3];
                    end
                    16'h0006: dyn[addr[3:0]] = 1'b0;
                    default: ;
                endcase
            end
        end
    end

    // Dynamic and temporary bits survive a hardware reset
    always @(negedge reset_b) begin
        lock = !pwd_mode;
        in_op = 1'b0;
        ucnt = 3'h0;
        in_sec = 1'b0;
    end
endmodule : fsp_flash_model

/* File: test/test_flash_sector_protection.sv */
`timescale 1ns/10ps
module test_flash_sector_protection;
    localparam logic [15:0] CB = 16'h00c0;
    localparam logic [15:0] SN = 16'h5a00;
    localparam logic [31:0] WR = 32'h0000_0001;
    localparam logic [31:0] RD = 32'h0000_0003;
    localparam logic [31:0] PL = 32'h0000_0015;
    localparam logic [31:0] UL = 32'h0000_0007;
    localparam logic [31:0] HR = 32'h0000_0009;
    logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, lerr;
    logic dq_oe, ce_b, oe_b, we_b, frst_b;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r, x, p0, p1;
    logic [fsp_pkg::ADDR_W-1:0] fa, sa;
    logic [fsp_pkg::DATA_W-1:0] dq_i, dq_o;
    logic [3:0] busy_len;
    logic [31:0] seed = 32'h1d57;
    int n_errors = 0;
    int comparisons = 0;
    time t0;

    fsp_host fsp_host_i (
        .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_addr(fa), .flash_dq_i(dq_i), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe),
        .flash_ce_b(ce_b), .flash_oe_b(oe_b), .flash_we_b(we_b), .flash_reset_b(frst_b)
    );
    fsp_flash_model #(.CMD_BASE(CB), .SN_BASE(SN)) fsp_flash_model_i (
        .addr(fa), .dq_o(dq_o), .dq_oe(dq_oe), .ce_b(ce_b), .oe_b(oe_b), .we_b(we_b),
        .reset_b(frst_b), .busy_len(busy_len), .dq_i(dq_i)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Status word of a sector whose temporary bit is never touched, on a factory-locked part
    function automatic logic [31:0] se(input logic lk, input logic nv, input logic dy);
        return {26'h0, 1'b1, lk, 1'b1, nv, dy, !dy || !nv};
    endfunction : se

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r = prdata;
        lerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    // Leaves the final status word in r
    task automatic op(input logic [31:0] c);
        apb(1'b1, fsp_pkg::OFS_CTRL, c);
        r = 32'h0000_0001;
        for (int n = 0; n < 500 && r[0] !== 1'b0; n++) apb(1'b0, fsp_pkg::OFS_STATUS, 32'h0);
        chk({31'h0, r[0]}, 32'h0000_0000);
    endtask : op

    task automatic cmd(input logic [25:0] a, input logic [15:0] d, input logic [31:0] c);
        apb(1'b1, fsp_pkg::OFS_ADDR, 32'(a));
        apb(1'b1, fsp_pkg::OFS_WDATA, 32'(d));
        op(c);
    endtask : cmd

    task automatic stat(input logic [25:0] a, input logic [31:0] e);
        cmd(a, CB + 16'h0007, WR);
        cmd(a, 16'h0000, RD);
        apb(1'b0, fsp_pkg::OFS_RDATA, 32'h0);
        chk({16'h0, r[15:0]}, e);
    endtask : stat

    task automatic poll(input logic [25:0] a, input logic [15:0] c, input logic [31:0] e);
        cmd(a, c, WR);
        apb(1'b1, fsp_pkg::OFS_STATUS, 32'h0000_0016);
        op(PL | {25'h0, c[1], 6'h00});
        chk({29'h0, r[2:0]}, e);
    endtask : poll

    task automatic give_verdict();
        $display("Errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #300000;
        n_errors++;
        give_verdict();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, busy_len, rst_b} = '0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        apb(1'b0, fsp_pkg::OFS_PWD_HI, 32'h0);
        chk(r, 32'hffff_ffff);
        apb(1'b0, 8'h40, 32'h0);
        chk({r[30:0], lerr}, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            x = rnd();
            busy_len <= x[3:0];
            sa = 26'(x[7:4]);
            poll(sa, CB + 16'h0001, 32'h0000_0002);
            chk({31'h0, r[3]}, 32'h0000_0001);
            stat(sa, se(1'b1, 1'b0, 1'b1));
        end
        cmd(26'h0, CB + 16'h0003, 32'h0000_0021);
        chk({31'h0, r[3]}, 32'h0000_0000);
        poll(sa, CB + 16'h0001, 32'h0000_0004);
        poll(sa, CB + 16'h0002, 32'h0000_0004);
        op(HR);
        poll(sa, CB + 16'h0002, 32'h0000_0002);
        stat(sa, se(1'b1, 1'b1, 1'b1));
        cmd(26'h0, CB + 16'h0009, WR);
        cmd(26'h3, CB + 16'h0001, WR);
        cmd(26'h3, 16'h0000, RD);
        apb(1'b0, fsp_pkg::OFS_RDATA, 32'h0);
        chk({16'h0, r[15:0]}, {16'h0, SN + 16'h0003});
        cmd(26'h0, CB + 16'h000a, WR);
        stat(26'h3, se(1'b1, 1'b1, 1'b1));
        cmd(sa, CB + 16'h0006, WR);
        op(HR);
        stat(sa, se(1'b1, 1'b1, 1'b0));
        apb(1'b1, fsp_pkg::OFS_CTRL, WR);
        op(WR);
        chk({31'h0, r[4]}, 32'h0000_0001);
        p0 = rnd();
        p1 = rnd();
        apb(1'b1, fsp_pkg::OFS_PWD_LO, p0);
        apb(1'b1, fsp_pkg::OFS_PWD_HI, p1);
        cmd(26'h0, CB + 16'h0008, WR);
        op(UL);
        cmd(26'h6, CB + 16'h0004, WR);
        op(HR);
        stat(~sa, se(1'b1, 1'b1, 1'b1));
        cmd(26'h4, CB + 16'h0004, WR);
        op(HR);
        stat(~sa, se(1'b0, 1'b1, 1'b1));
        apb(1'b1, fsp_pkg::OFS_PWD_LO, 32'h0);
        apb(1'b1, fsp_pkg::OFS_PWD_HI, 32'h0);
        cmd(26'h0, CB + 16'h0008, WR);
        op(UL);
        cmd(26'h0, CB + 16'h0005, WR);
        op(UL);
        stat(~sa, se(1'b0, 1'b1, 1'b1));
        apb(1'b1, fsp_pkg::OFS_PWD_LO, p0);
        apb(1'b1, fsp_pkg::OFS_PWD_HI, p1);
        cmd(26'h0, CB + 16'h0005, WR);
        t0 = $time;
        op(UL);
        chk({31'h0, ($time - t0) >= 2000}, 32'h0000_0001);
        stat(~sa, se(1'b1, 1'b1, 1'b1));
        give_verdict();
    end
endmodule : test_flash_sector_protection
